// ==== rtl/aix_regs.vh ====
// Purpose: Register map and field constants for the auxiliary interrupt block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: Definitions only
`ifndef AIX_REGS_VH
`define AIX_REGS_VH

// Register addresses
`define AIX_ADDR_PEND_IDX  8'ha5
`define AIX_ADDR_AUX_EN    8'ha6
`define AIX_ADDR_AUX_STAT  8'ha7
`define AIX_ADDR_WAKE_EN   8'hc6
`define AIX_ADDR_EXT_CTRL  8'hd8
`define AIX_ADDR_LV_CTRL   8'he7
`define AIX_ADDR_SPI_RXCFG 8'h9a
`define AIX_ADDR_SPI_TXCFG 8'h9b
`define AIX_ADDR_SEC_INT   8'hf9
`define AIX_ADDR_MS_INT    8'hfa
`define AIX_ADDR_MS_PS_LO  8'hfc
`define AIX_ADDR_MS_PS_HI  8'hfd
`define AIX_ADDR_HS_PS     8'hfe

// Control bit positions
`define AIX_EXT_AUX_EN     5
`define AIX_EXT_AUX_PEND   4
`define AIX_LV_DIG_EN      7
`define AIX_LV_ANA_EN      6
`define AIX_WAKE_WDT       2
`define AIX_WAKE_EX1       1
`define AIX_WAKE_EX0       0

// Source bit positions in enable and status
`define AIX_SRC_DLV        0
`define AIX_SRC_ALV        1
`define AIX_SRC_SPIR       2
`define AIX_SRC_SPIT       3
`define AIX_SRC_MS         4
`define AIX_SRC_ADC        5
`define AIX_SRC_SUM        6
`define AIX_SRC_SEC        7

// Reset values and constants
`define AIX_RST_BYTE       8'h00
`define AIX_RST_MS_PS      16'h0000
`define AIX_VECTOR_ADDR    16'h0033
`define AIX_HS_PER_SEC     8'h64
`define AIX_SUM_MODE1      2'h1
`define AIX_SUM_MODE3      2'h3
`endif

// ==== rtl/aix_irq_ctrl.v ====
// Purpose: Auxiliary interrupt aggregation, pending index and idle wake-up
// Assumes: 20 MHz clk, synchronous active-high rst, peripheral strobes on clk
// Notes: Supply level codes come from analog pins and are synchronised
`timescale 1ns/10ps
`include "aix_regs.vh"

// Function
// - Status register ignores all writes
// - Software sets pending flag, source unselectable
// - Taken interrupt vectors to 0033h
// - Index in bits 3:0, range 0..8
// - Index reads zero when nothing pending
// - Index ranks sources one through eight
// - One shared interrupt, rank only indexes
// - Two supply detectors against chosen threshold
// - Low-voltage sources are level sensitive
// - Aux enable gates; global enable ignored
// - SPI sources fire at configured counts
// - Millisecond source every n ticks
// - Millisecond tick from 16-bit prescaler
// - Seconds from ms and hundredth prescalers
// - ADC source set by result, cleared reading
// - Summation source only in modes 1,3
// - Wake enable bits 2,1,0 plus aux
// - Cleared wake bit blocks that wake
// - Status shows enabled and true sources
module aix_irq_ctrl #(
    parameter AW = 8,
    parameter DW = 8,
    parameter LVW = 4
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst,
    // Register port
    input  wire [AW-1:0] reg_addr,
    input  wire [DW-1:0] reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [DW-1:0] reg_rdata,
    // Supply level codes, asynchronous
    input  wire [LVW-1:0] avdd_level,
    input  wire [LVW-1:0] dvdd_level,
    // Peripheral events
    input  wire          bp_hit,
    input  wire          bp_clear,
    input  wire          spi_rx_byte,
    input  wire          spi_tx_byte,
    input  wire          spi_data_rd,
    input  wire          spi_data_wr,
    input  wire          adc_result_new,
    input  wire          adc_result_low_rd,
    input  wire          sum_done,
    input  wire [1:0]    sum_mode,
    input  wire          sum_result_byte0_rd,
    // Core side
    input  wire          idle_mode,
    input  wire          wdt_irq,
    input  wire          ext_irq1,
    input  wire          ext_irq0,
    output wire          aux_irq_req,
    output reg  [15:0]   aux_vector,
    output reg           wake_up
);

    // Lowest set status bit wins the index
    function [3:0] pend_index;
        input [7:0] st;
        integer i;
        begin
            pend_index = 4'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (st[i]) begin
                    pend_index = i[3:0] + 4'h1;
                end
            end
        end
    endfunction

    // Software registers
    reg  [7:0]  aux_enable_reg;
    reg  [7:0]  wake_enable_reg;
    reg         aux_irq_enable;
    reg         aux_pending_flag;
    reg  [7:0]  low_voltage_threshold_ctrl;
    reg  [7:0]  spi_rx_count_cfg;
    reg  [7:0]  spi_tx_count_cfg;
    reg  [7:0]  ms_interval_count;
    reg  [7:0]  sec_interval_count;
    reg  [7:0]  ms_prescale_low;
    reg  [7:0]  ms_prescale_high;
    reg  [7:0]  hundredth_sec_prescale;

    // Internal state
    reg  [LVW-1:0] av_s1_reg;
    reg  [LVW-1:0] av_s2_reg;
    reg  [LVW-1:0] dv_s1_reg;
    reg  [LVW-1:0] dv_s2_reg;
    reg         bp_flag_reg;
    reg  [7:0]  spi_rx_cnt_reg;
    reg  [7:0]  spi_tx_cnt_reg;
    reg         spir_flag_reg;
    reg         spit_flag_reg;
    reg  [15:0] ms_ps_cnt_reg;
    reg  [7:0]  ms_int_cnt_reg;
    reg         ms_flag_reg;
    reg  [7:0]  hs_cnt_reg;
    reg  [7:0]  hs_per_sec_reg;
    reg  [7:0]  sec_int_cnt_reg;
    reg         sec_flag_reg;
    reg         adc_flag_reg;
    reg         sum_flag_reg;

    wire [7:0]  cond;
    wire [7:0]  status;
    wire        dlv_low;
    wire        alv_low;
    wire        ms_tick;
    wire        hs_tick;
    wire        sec_tick;
    wire        rd_ms_int;
    wire        rd_sec_int;
    wire        wr_ext;

    // Register access decodes
    assign rd_ms_int  = reg_rd && (reg_addr == `AIX_ADDR_MS_INT);
    assign rd_sec_int = reg_rd && (reg_addr == `AIX_ADDR_SEC_INT);
    assign wr_ext     = reg_wr && (reg_addr == `AIX_ADDR_EXT_CTRL);

    // Supply codes cross from analog pins
    always @(posedge clk) begin
        if (rst) begin
            av_s1_reg <= {LVW{1'b0}};
            av_s2_reg <= {LVW{1'b0}};
            dv_s1_reg <= {LVW{1'b0}};
            dv_s2_reg <= {LVW{1'b0}};
        end else begin
            av_s1_reg <= avdd_level;
            av_s2_reg <= av_s1_reg;
            dv_s1_reg <= dvdd_level;
            dv_s2_reg <= dv_s1_reg;
        end
    end

    // Level compare, no latch: clears as supply recovers
    assign alv_low = low_voltage_threshold_ctrl[`AIX_LV_ANA_EN] &&
                     (av_s2_reg < low_voltage_threshold_ctrl[LVW-1:0]);
    assign dlv_low = low_voltage_threshold_ctrl[`AIX_LV_DIG_EN] &&
                     (dv_s2_reg < low_voltage_threshold_ctrl[LVW-1:0]);

    // Live conditions, independent of enables
    assign cond[`AIX_SRC_DLV]  = dlv_low | bp_flag_reg;
    assign cond[`AIX_SRC_ALV]  = alv_low;
    assign cond[`AIX_SRC_SPIR] = spir_flag_reg;
    assign cond[`AIX_SRC_SPIT] = spit_flag_reg;
    assign cond[`AIX_SRC_MS]   = ms_flag_reg;
    assign cond[`AIX_SRC_ADC]  = adc_flag_reg;
    assign cond[`AIX_SRC_SUM]  = sum_flag_reg;
    assign cond[`AIX_SRC_SEC]  = sec_flag_reg;
    assign status = cond & aux_enable_reg;

    // Breakpoint flag; set beats clear
    always @(posedge clk) begin
        if (rst) begin
            bp_flag_reg <= 1'b0;
        end else if (bp_hit) begin
            bp_flag_reg <= 1'b1;
        end else if (bp_clear) begin
            bp_flag_reg <= 1'b0;
        end
    end

    // SPI byte counters; only a count-completing byte beats a clear
    always @(posedge clk) begin
        if (rst) begin
            spi_rx_cnt_reg <= `AIX_RST_BYTE;
            spi_tx_cnt_reg <= `AIX_RST_BYTE;
            spir_flag_reg  <= 1'b0;
            spit_flag_reg  <= 1'b0;
        end else begin
            if (spi_rx_byte && (spi_rx_cnt_reg + 8'h01 >= spi_rx_count_cfg)) begin
                spi_rx_cnt_reg <= `AIX_RST_BYTE;
                spir_flag_reg  <= 1'b1;
            end else begin
                if (spi_rx_byte) begin
                    spi_rx_cnt_reg <= spi_rx_cnt_reg + 8'h01;
                end
                if (spi_data_rd) begin
                    spir_flag_reg <= 1'b0;
                end
            end
            if (spi_tx_byte && (spi_tx_cnt_reg + 8'h01 >= spi_tx_count_cfg)) begin
                spi_tx_cnt_reg <= `AIX_RST_BYTE;
                spit_flag_reg  <= 1'b1;
            end else begin
                if (spi_tx_byte) begin
                    spi_tx_cnt_reg <= spi_tx_cnt_reg + 8'h01;
                end
                if (spi_data_wr) begin
                    spit_flag_reg <= 1'b0;
                end
            end
        end
    end

    // Ms prescaler: period is prescale value plus one clocks
    assign ms_tick = (ms_ps_cnt_reg == {ms_prescale_high, ms_prescale_low});
    assign hs_tick = ms_tick && (hs_cnt_reg == hundredth_sec_prescale);
    assign sec_tick = hs_tick && (hs_per_sec_reg == `AIX_HS_PER_SEC - 8'h01);

    always @(posedge clk) begin
        if (rst) begin
            ms_ps_cnt_reg  <= `AIX_RST_MS_PS;
            hs_cnt_reg     <= `AIX_RST_BYTE;
            hs_per_sec_reg <= `AIX_RST_BYTE;
        end else begin
            ms_ps_cnt_reg <= ms_tick ? `AIX_RST_MS_PS : ms_ps_cnt_reg + 16'h0001;
            if (ms_tick) begin
                hs_cnt_reg <= hs_tick ? `AIX_RST_BYTE : hs_cnt_reg + 8'h01;
            end
            if (hs_tick) begin
                hs_per_sec_reg <= sec_tick ? `AIX_RST_BYTE : hs_per_sec_reg + 8'h01;
            end
        end
    end

    // Interval counters; a read of the interval register clears
    always @(posedge clk) begin
        if (rst) begin
            ms_int_cnt_reg  <= `AIX_RST_BYTE;
            sec_int_cnt_reg <= `AIX_RST_BYTE;
            ms_flag_reg     <= 1'b0;
            sec_flag_reg    <= 1'b0;
        end else begin
            if (ms_tick) begin
                if (ms_int_cnt_reg + 8'h01 >= ms_interval_count) begin
                    ms_int_cnt_reg <= `AIX_RST_BYTE;
                    ms_flag_reg    <= 1'b1;
                end else begin
                    ms_int_cnt_reg <= ms_int_cnt_reg + 8'h01;
                end
            end else if (rd_ms_int) begin
                ms_flag_reg <= 1'b0;
            end
            if (sec_tick) begin
                if (sec_int_cnt_reg + 8'h01 >= sec_interval_count) begin
                    sec_int_cnt_reg <= `AIX_RST_BYTE;
                    sec_flag_reg    <= 1'b1;
                end else begin
                    sec_int_cnt_reg <= sec_int_cnt_reg + 8'h01;
                end
            end else if (rd_sec_int) begin
                sec_flag_reg <= 1'b0;
            end
        end
    end

    // ADC and summation completion flags
    always @(posedge clk) begin
        if (rst) begin
            adc_flag_reg <= 1'b0;
            sum_flag_reg <= 1'b0;
        end else begin
            if (adc_result_new) begin
                adc_flag_reg <= 1'b1;
            end else if (adc_result_low_rd) begin
                adc_flag_reg <= 1'b0;
            end
            if (sum_done && (sum_mode == `AIX_SUM_MODE1 ||
                             sum_mode == `AIX_SUM_MODE3)) begin
                sum_flag_reg <= 1'b1;
            end else if (sum_result_byte0_rd) begin
                sum_flag_reg <= 1'b0;
            end
        end
    end

    // Pending flag: hardware set wins over a software write of the pending bit
    always @(posedge clk) begin
        if (rst) begin
            aux_pending_flag <= 1'b0;
        end else if (aux_irq_enable && (status != 8'h00)) begin
            aux_pending_flag <= 1'b1;
        end else if (wr_ext) begin
            aux_pending_flag <= reg_wdata[`AIX_EXT_AUX_PEND];
        end
    end

    // Single shared request; global enable deliberately not an input
    assign aux_irq_req = aux_irq_enable & aux_pending_flag;

    // Software-written registers
    always @(posedge clk) begin
        if (rst) begin
            aux_enable_reg             <= `AIX_RST_BYTE;
            wake_enable_reg            <= `AIX_RST_BYTE;
            aux_irq_enable             <= 1'b0;
            low_voltage_threshold_ctrl <= `AIX_RST_BYTE;
            spi_rx_count_cfg           <= `AIX_RST_BYTE;
            spi_tx_count_cfg           <= `AIX_RST_BYTE;
            ms_interval_count          <= `AIX_RST_BYTE;
            sec_interval_count         <= `AIX_RST_BYTE;
            ms_prescale_low            <= `AIX_RST_BYTE;
            ms_prescale_high           <= `AIX_RST_BYTE;
            hundredth_sec_prescale     <= `AIX_RST_BYTE;
        end else if (reg_wr) begin
            // Status and index addresses fall to default
            case (reg_addr)
                `AIX_ADDR_AUX_EN: begin
                    aux_enable_reg <= reg_wdata;
                end
                `AIX_ADDR_WAKE_EN: begin
                    wake_enable_reg <= {5'h00, reg_wdata[2:0]};
                end
                `AIX_ADDR_EXT_CTRL: begin
                    aux_irq_enable <= reg_wdata[`AIX_EXT_AUX_EN];
                end
                `AIX_ADDR_LV_CTRL: begin
                    low_voltage_threshold_ctrl <= reg_wdata;
                end
                `AIX_ADDR_SPI_RXCFG: begin
                    spi_rx_count_cfg <= reg_wdata;
                end
                `AIX_ADDR_SPI_TXCFG: begin
                    spi_tx_count_cfg <= reg_wdata;
                end
                `AIX_ADDR_MS_INT: begin
                    ms_interval_count <= reg_wdata;
                end
                `AIX_ADDR_SEC_INT: begin
                    sec_interval_count <= reg_wdata;
                end
                `AIX_ADDR_MS_PS_LO: begin
                    ms_prescale_low <= reg_wdata;
                end
                `AIX_ADDR_MS_PS_HI: begin
                    ms_prescale_high <= reg_wdata;
                end
                `AIX_ADDR_HS_PS: begin
                    hundredth_sec_prescale <= reg_wdata;
                end
                default: begin
                    aux_enable_reg <= aux_enable_reg;
                end
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `AIX_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `AIX_ADDR_PEND_IDX:  reg_rdata <= {4'h0, pend_index(status)};
                `AIX_ADDR_AUX_EN:    reg_rdata <= cond; // Raw conditions, ignoring enables
                `AIX_ADDR_AUX_STAT:  reg_rdata <= status;
                `AIX_ADDR_WAKE_EN:   reg_rdata <= wake_enable_reg;
                `AIX_ADDR_EXT_CTRL:  reg_rdata <= {2'h0, aux_irq_enable, aux_pending_flag, 4'h0};
                `AIX_ADDR_LV_CTRL:   reg_rdata <= low_voltage_threshold_ctrl;
                `AIX_ADDR_SPI_RXCFG: reg_rdata <= spi_rx_count_cfg;
                `AIX_ADDR_SPI_TXCFG: reg_rdata <= spi_tx_count_cfg;
                `AIX_ADDR_MS_INT:    reg_rdata <= ms_interval_count;
                `AIX_ADDR_SEC_INT:   reg_rdata <= sec_interval_count;
                `AIX_ADDR_MS_PS_LO:  reg_rdata <= ms_prescale_low;
                `AIX_ADDR_MS_PS_HI:  reg_rdata <= ms_prescale_high;
                `AIX_ADDR_HS_PS:     reg_rdata <= hundredth_sec_prescale;
                default:             reg_rdata <= `AIX_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `AIX_RST_BYTE;
        end
    end

    // Fixed vector and registered wake request
    always @(posedge clk) begin
        if (rst) begin
            aux_vector <= `AIX_VECTOR_ADDR;
            wake_up    <= 1'b0;
        end else begin
            aux_vector <= `AIX_VECTOR_ADDR;
            wake_up    <= idle_mode &&
                ((wake_enable_reg[`AIX_WAKE_WDT] && wdt_irq) ||
                 (wake_enable_reg[`AIX_WAKE_EX1] && ext_irq1) ||
                 (wake_enable_reg[`AIX_WAKE_EX0] && ext_irq0) ||
                 aux_irq_req);
        end
    end

endmodule

// ==== tb/aix_irq_ctrl_asserts.sv ====
// Purpose: Port-level checks for the auxiliary interrupt block
// Assumes: Control fields are shadowed from register writes
// Notes: Shadows hold the fields these checks need; the supply control byte is kept whole
`timescale 1ns/10ps
module aix_irq_ctrl_chk (
    // Clock and reset
    input wire        clk,
    input wire        rst,
    // Register port
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // Supply and core side
    input wire [3:0]  dvdd_level,
    input wire        idle_mode,
    input wire        wdt_irq,
    input wire        ext_irq1,
    input wire        ext_irq0,
    input wire        aux_irq_req,
    input wire [15:0] aux_vector,
    input wire        wake_up
);
    reg       en_reg;
    reg [7:0] aie_reg;
    reg [7:0] lv_reg;
    reg [2:0] wk_reg;
    // Digital detector enabled, routed and below threshold
    wire      lv_low = en_reg && aie_reg[0] && lv_reg[7] && (dvdd_level < lv_reg[3:0]);
    wire      wk_hit = |({wdt_irq, ext_irq1, ext_irq0} & wk_reg);

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Shadow of written control fields, updated on the same edge as the design
    always @(posedge clk) begin
        if (rst) begin
            en_reg  <= 1'b0;
            aie_reg <= 8'h00;
            lv_reg  <= 8'h00;
            wk_reg  <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == 8'hd8) en_reg <= reg_wdata[5];
            if (reg_addr == 8'ha6) aie_reg <= reg_wdata;
            if (reg_addr == 8'he7) lv_reg <= reg_wdata;
            if (reg_addr == 8'hc6) wk_reg <= reg_wdata[2:0];
        end
    end

    a_vector_fixed: assert property (aux_vector == 16'h0033)
        else $error("aux vector differs from handler address");
    a_index_range: assert property (reg_rd && reg_addr == 8'ha5 |=> reg_rdata <= 8'h08)
        else $error("pending index out of range");
    a_status_enabled: assert property (reg_rd && reg_addr == 8'ha7 |=> (reg_rdata & ~aie_reg) == 8'h00)
        else $error("status shows a source that is not enabled");
    a_irq_gated: assert property (aux_irq_req |-> en_reg)
        else $error("aux request while aux enable clear");
    a_sw_pending: assert property (reg_wr && reg_addr == 8'hd8 && reg_wdata[5:4] == 2'b11 |=> aux_irq_req)
        else $error("software pending flag raised no request");
    a_wake_cause: assert property (wake_up |-> $past(idle_mode) && ($past(wk_hit) || $past(aux_irq_req)))
        else $error("wake without an enabled cause");
    a_wake_follow: assert property (idle_mode && wk_hit |=> wake_up)
        else $error("enabled cause did not wake");
    a_lv_raise: assert property (lv_low [*6] |-> aux_irq_req)
        else $error("low supply did not hold the request");
endmodule

bind aix_irq_ctrl aix_irq_ctrl_chk u_chk (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .dvdd_level, .idle_mode, .wdt_irq, .ext_irq1, .ext_irq0,
    .aux_irq_req, .aux_vector, .wake_up
);

// ==== tb/aix_periph_model.sv ====
// Purpose: Peripheral event sources and supply monitors
// Assumes: Requests change just after a clk edge
// Notes: Healthy supply code sits above every threshold used
`timescale 1ns/10ps
module aix_periph_model (
    // Bench requests
    input  wire [9:0] ev_req,
    input  wire       low_a,
    input  wire       low_d,
    // Event strobes, one cycle each
    output wire [9:0] ev_out,
    // Supply codes
    output wire [3:0] avdd_level,
    output wire [3:0] dvdd_level
);
    // Strobes last exactly as long as the request
    assign ev_out = ev_req;
    // Code 3 lies under threshold 8, code c above it
    assign avdd_level = low_a ? 4'h3 : 4'hc;
    assign dvdd_level = low_d ? 4'h3 : 4'hc;
endmodule

// ==== tb/aix_irq_ctrl_tb.sv ====
// Purpose: Register-level tests of the auxiliary interrupt block
// Assumes: 50 ns clock, short prescaler values written by the bench
// Notes: Timer periods are measured rise to rise of the request
`timescale 1ns/10ps
module aix_irq_ctrl_tb;
    reg         clk, rst, reg_wr, reg_rd, low_a, low_d;
    reg         idle_mode, wdt_irq, ext_irq1, ext_irq0;
    reg  [7:0]  reg_addr, reg_wdata, v;
    reg  [9:0]  ev_req;
    reg  [1:0]  sum_mode;
    wire [7:0]  reg_rdata;
    wire [3:0]  avdd_level, dvdd_level;
    wire [9:0]  ev;
    wire        aux_irq_req, wake_up;
    wire [15:0] aux_vector;
    integer     errors, checked, t0, m;
    integer     cyc_cnt = 0;

    aix_periph_model u_src (.ev_req(ev_req), .low_a(low_a), .low_d(low_d), .ev_out(ev),
        .avdd_level(avdd_level), .dvdd_level(dvdd_level));
    aix_irq_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .avdd_level(avdd_level),
        .dvdd_level(dvdd_level), .bp_hit(ev[0]), .bp_clear(ev[1]), .spi_rx_byte(ev[2]),
        .spi_tx_byte(ev[3]), .spi_data_rd(ev[4]), .spi_data_wr(ev[5]),
        .adc_result_new(ev[6]), .adc_result_low_rd(ev[7]), .sum_done(ev[8]),
        .sum_mode(sum_mode), .sum_result_byte0_rd(ev[9]), .idle_mode(idle_mode),
        .wdt_irq(wdt_irq), .ext_irq1(ext_irq1), .ext_irq0(ext_irq0),
        .aux_irq_req(aux_irq_req), .aux_vector(aux_vector), .wake_up(wake_up));

    // Clock and free cycle count
    always #25 clk = ~clk;
    always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

    task conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Timed tasks other than do_reset end 1 ns after an edge so flags are settled
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task w(input [7:0] a, input [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rc(input [7:0] a, input [7:0] exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        if (nm != "") chk(nm, exp, v);
    endtask
    task p(input integer b);
        @(posedge clk);
        ev_req <= 10'h001 << b;
        @(posedge clk);
        ev_req <= 10'h000;
        #1;
    endtask
    task irq(input [7:0] exp);
        chk("irq", exp, {7'h00, aux_irq_req});
    endtask
    task wait_irq;
        integer k;
        for (k = 0; k < 1000 && aux_irq_req !== 1'b1; k = k + 1) tick(1);
    endtask
    // Clear source by reading its interval register, then the pending flag
    task clr_wait(input [7:0] a);
        integer j;
        // A tick on the read edge keeps the flag; retry one cycle off phase
        for (j = 0; j < 8 && aux_irq_req === 1'b1; j = j + 1) begin
            rc(a, 8'h00, "");
            w(8'hd8, 8'h20);
            if (aux_irq_req === 1'b1) tick(1);
        end
        wait_irq;
    endtask
    // First rise may be out of phase after a change; time the next one
    task period(input [7:0] a, input [7:0] exp, input string nm);
        wait_irq;
        clr_wait(a);
        t0 = cyc_cnt;
        clr_wait(a);
        chk(nm, exp, 8'(cyc_cnt - t0));
        $display("test %s done", nm);
    endtask
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Hang guard, over ten times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        errors = errors + 1;
        conclude;
    end

    initial begin
        clk = 0; rst = 1; reg_wr = 0; reg_rd = 0; low_a = 0; low_d = 0;
        idle_mode = 0; wdt_irq = 0; ext_irq1 = 0; ext_irq0 = 0;
        reg_addr = 8'h00; reg_wdata = 8'h00; ev_req = 10'h000; sum_mode = 2'h0;
        errors = 0; checked = 0;
        do_reset;
        rc(8'ha5, 8'h00, "index");
        rc(8'h00, 8'h00, "unmapped");
        w(8'hc6, 8'hff);
        rc(8'hc6, 8'h07, "wake_en");
        // Timer sources run free at reset prescales; keep them masked
        w(8'ha6, 8'h6f);
        w(8'hd8, 8'h20);
        w(8'ha7, 8'hff);
        rc(8'ha7, 8'h00, "status");
        irq(8'h00);
        w(8'hd8, 8'h00);
        $display("test read_only done");
        // Ranking of the pending index as sources come and go
        p(6);
        rc(8'ha7, 8'h20, "status");
        rc(8'ha5, 8'h06, "index");
        p(2);
        rc(8'ha7, 8'h24, "status");
        rc(8'ha5, 8'h03, "index");
        p(0);
        rc(8'ha5, 8'h01, "index");
        p(1);
        rc(8'ha5, 8'h03, "index");
        p(4);
        rc(8'ha5, 8'h06, "index");
        p(7);
        rc(8'ha5, 8'h00, "index");
        w(8'h9b, 8'h02);
        p(3);
        rc(8'ha7, 8'h00, "status");
        p(3);
        rc(8'ha5, 8'h04, "index");
        p(5);
        rc(8'ha7, 8'h00, "status");
        for (m = 0; m < 4; m = m + 1) begin
            @(posedge clk);
            sum_mode <= m[1:0];
            p(8);
            rc(8'ha5, m[0] ? 8'h07 : 8'h00, "index");
            p(9);
            rc(8'ha7, 8'h00, "status");
        end
        w(8'ha6, 8'h00);
        p(6);
        rc(8'ha7, 8'h00, "status");
        // Raw view also shows the free-running ms and seconds flags
        rc(8'ha6, 8'hb0, "raw");
        p(7);
        w(8'ha6, 8'h6f);
        $display("test ranking done");
        // Shared request, handler order and software set
        w(8'hd8, 8'h20);
        p(6);
        tick(2);
        irq(8'h01);
        w(8'hd8, 8'h20);
        tick(2);
        irq(8'h01);
        p(7);
        w(8'hd8, 8'h20);
        tick(2);
        irq(8'h00);
        w(8'hd8, 8'h30);
        irq(8'h01);
        rc(8'ha5, 8'h00, "index");
        w(8'hd8, 8'h00);
        irq(8'h00);
        $display("test request done");
        // Supply detectors, level held while low
        w(8'ha6, 8'h03);
        w(8'hd8, 8'h20);
        w(8'he7, 8'h08);
        @(posedge clk);
        low_d <= 1'b1;
        tick(5);
        rc(8'ha7, 8'h00, "status");
        w(8'he7, 8'h88);
        tick(5);
        rc(8'ha5, 8'h01, "index");
        low_a <= 1'b1;
        w(8'he7, 8'hc8);
        tick(25);
        rc(8'ha7, 8'h03, "status");
        irq(8'h01);
        low_a <= 1'b0;
        low_d <= 1'b0;
        tick(5);
        rc(8'ha7, 8'h00, "status");
        $display("test supply done");
        // Timer periods scale with prescaler and interval
        w(8'ha6, 8'h10);
        w(8'hfc, 8'h03);
        w(8'hfa, 8'h02);
        period(8'hfa, 8'd8, "ms");
        w(8'hfc, 8'h07);
        period(8'hfa, 8'd16, "ms");
        w(8'hfa, 8'h04);
        period(8'hfa, 8'd32, "ms");
        do_reset;
        w(8'hd8, 8'h20);
        w(8'ha6, 8'h80);
        w(8'hf9, 8'h01);
        period(8'hf9, 8'd100, "sec");
        w(8'hfe, 8'h01);
        period(8'hf9, 8'd200, "sec");
        // Wake from idle, each line blocked then allowed
        w(8'hd8, 8'h00);
        idle_mode <= 1'b1;
        for (m = 0; m < 3; m = m + 1) begin
            w(8'hc6, 8'h00);
            {wdt_irq, ext_irq1, ext_irq0} <= 3'b001 << m;
            tick(3);
            chk("wake", 8'h00, {7'h00, wake_up});
            w(8'hc6, 8'h01 << m);
            tick(1); // Wake is registered one edge after the enable lands
            chk("wake", 8'h01, {7'h00, wake_up});
            {wdt_irq, ext_irq1, ext_irq0} <= 3'b000;
            tick(2);
        end
        w(8'hd8, 8'h30);
        tick(1);
        chk("wake", 8'h01, {7'h00, wake_up});
        w(8'hd8, 8'h00);
        idle_mode <= 1'b0;
        $display("test wake done");
        conclude;
    end
endmodule
